// file: dv/encoder_status_and_ttx_line_mask_test.sv
// Purpose: Self-checking bench for status byte and line mask.
// Assumes: Host model paces the bus at four clk per step.
// Notes:   Expected status is VERSION_EXP plus literal low bits per call.
`timescale 1ns/1ns
module encoder_status_and_ttx_line_mask_test;
	import ves_pkg::*;
	localparam logic [2:0] VERSION_EXP = 3'h2; // Arbitrary value
	logic            clk, rst_b, scl, sdaLow, sdaOut, sdaOe, win;
	logic            palMode, fieldStart, oddEnc, evenEnc, enable;
	logic [9:0]      lineNumber;
	ves_ttx_window_s window;
	int              miscompares, num_checks;
	wire             sdaWire = !(sdaLow || sdaOe); // Any low drive wins over the pull-up
	localparam logic [7:0] RA = BUS_ADDR_A | 8'h01;
	ves_host_model host (.clk(clk), .sdaWire(sdaWire), .scl(scl),
		.sdaLow(sdaLow));
	ves_status_top #(.VERSION_CODE(VERSION_EXP)) uut (.clk(clk),
		.rst_b(rst_b), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.palMode(palMode), .fieldStart(fieldStart),
		.oddCaptionEncoded(oddEnc), .evenCaptionEncoded(evenEnc),
		.lineNumber(lineNumber), .window(window),
		.teletextInsertEnable(enable), .ttxInsertWindow(win));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic doReset();
		@(posedge clk) rst_b <= 1'h0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
	endtask
	// Read one status byte, NACK, stop; compare with expected low bits
	task automatic status(input logic [7:0] addr, input logic [4:0] low);
		logic [7:0] s;
		logic a;
		host.start();
		host.xfer(addr, 1'h1, s, a);
		check({7'h0, a}, 8'h01);
		host.xfer(8'hff, 1'h1, s, a);
		host.stop();
		check(s, {VERSION_EXP, low});
	endtask
	// Two data bytes, the second lands on the next subaddress
	task automatic wr(input logic [7:0] sub, d0, d1);
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer(BUS_ADDR_A, 1'h1, q, a);
		check({7'h0, a}, 8'h01);
		host.xfer(sub, 1'h1, q, a);
		check({7'h0, a}, 8'h01);
		host.xfer(d0, 1'h1, q, a);
		check({7'h0, a}, 8'h01);
		host.xfer(d1, 1'h1, q, a);
		check({7'h0, a}, 8'h01);
		host.stop();
	endtask
	task automatic pulseField(input int n);
		repeat (n) begin
			@(posedge clk) fieldStart <= 1'h1;
			@(posedge clk) fieldStart <= 1'h0;
		end
	endtask
	task automatic gate(input logic [9:0] ln, input logic e);
		@(posedge clk) lineNumber <= ln;
		repeat (3) @(posedge clk);
		check({7'h0, win}, {7'h0, e});
	endtask
	task automatic t_status();
		logic [7:0] s;
		logic       a;
		status(RA, 5'h00);
		status(BUS_ADDR_B | 8'h01, 5'h00);
		// A foreign address must leave the data line to the pull-up
		host.start();
		host.xfer(8'h8b, 1'h1, s, a);
		host.stop();
		check({7'h0, a}, 8'h00);
		$display("test status done");
	endtask
	task automatic t_caption();
		@(posedge clk) oddEnc <= 1'h1;
		@(posedge clk) oddEnc <= 1'h0;
		status(RA, 5'h10);
		@(posedge clk) evenEnc <= 1'h1;
		@(posedge clk) evenEnc <= 1'h0;
		status(RA, 5'h18);
		wr(SUB_CC_ODD_0, 8'h11, 8'h22);
		status(RA, 5'h08);
		wr(SUB_CC_EVEN_1, 8'h33, 8'h44);
		status(RA, 5'h00);
		$display("test caption done");
	endtask
	// Flag sets mid-byte: first byte keeps its snapshot, second sees it
	task automatic t_snap();
		logic [7:0] s;
		logic       a;
		host.start();
		host.xfer(RA, 1'h1, s, a);
		check({7'h0, a}, 8'h01);
		fork
			host.xfer(8'hff, 1'h0, s, a);
			begin
				repeat (30) @(posedge clk);
				oddEnc <= 1'h1;
				@(posedge clk) oddEnc <= 1'h0;
			end
		join
		check(s, {VERSION_EXP, 5'h00});
		host.xfer(8'hff, 1'h1, s, a);
		host.stop();
		check(s, {VERSION_EXP, 5'h10});
		$display("test snapshot done");
	endtask
	// PAL odd field: lines 6 to 22 open, mask vetoes 6 and 20
	task automatic t_ttx();
		@(posedge clk) window <= '{8'h05, 8'h16, 8'h05, 8'h16};
		palMode <= 1'h1;
		enable <= 1'h1;
		wr(SUB_LINE_MASK_LO, 8'h02, 8'h80);
		gate(10'h004, 1'h0);
		gate(10'h006, 1'h0);
		gate(10'h007, 1'h1);
		gate(10'h014, 1'h0);
		gate(10'h016, 1'h1);
		gate(10'h017, 1'h0);
		// NTSC odd field opens 10 to 19, even field 9 to 19
		@(posedge clk) window <= '{8'h06, 8'h10, 8'h05, 8'h10};
		palMode <= 1'h0;
		gate(10'h009, 1'h0);
		gate(10'h00a, 1'h1);
		gate(10'h013, 1'h1);
		gate(10'h015, 1'h0);
		pulseField(1);
		gate(10'h008, 1'h0);
		gate(10'h009, 1'h1);
		@(posedge clk) enable <= 1'h0;
		gate(10'h009, 1'h0);
		$display("test ttx done");
	endtask
	task automatic t_field_seq();
		@(posedge clk) palMode <= 1'h0;
		doReset();
		pulseField(5);
		status(RA, 5'h01);
		@(posedge clk) palMode <= 1'h1;
		doReset();
		pulseField(6);
		status(RA, 5'h06);
		pulseField(3);
		status(RA, 5'h01);
		$display("test field sequence done");
	endtask
	initial begin
		rst_b = 1'h0;
		palMode = 1'h0;
		fieldStart = 1'h0;
		oddEnc = 1'h0;
		evenEnc = 1'h0;
		enable = 1'h0;
		lineNumber = 10'h000;
		window = '0;
		miscompares = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		t_status();
		t_caption();
		t_snap();
		t_ttx();
		t_field_seq();
		finish_test();
	end
	// Whole run needs some 4k cycles; allow far more
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
endmodule
bind ves_status_top ves_status_properties chk (.clk(clk), .rst_b(rst_b),
	.scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.palMode(palMode), .lineNumber(lineNumber), .window(window),
	.teletextInsertEnable(teletextInsertEnable),
	.ttxInsertWindow(ttxInsertWindow));

// file: dv/ves_host_model.sv
// Purpose: Serial bus host master facing the slave port.
// Assumes: SDA has a pull-up; the host only pulls it low.
// Notes:   Four clk per bus step (SCL high four, low eight), twice what the slave needs.
`timescale 1ns/1ns
module ves_host_model (
	input  wire logic clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'h1;
		sdaLow = 1'h0;
	end
	// Pace every bus step in whole clk cycles
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data set in SCL low, sampled late in SCL high
	task automatic bitIo(input logic b, output logic r);
		sdaLow <= !b;
		tick(4);
		scl <= 1'h1;
		tick(4);
		r = sdaWire;
		scl <= 1'h0;
		tick(4);
	endtask
	// Also serves as a repeated start
	task automatic start();
		sdaLow <= 1'h0;
		tick(4);
		scl <= 1'h1;
		tick(4);
		sdaLow <= 1'h1;
		tick(4);
		scl <= 1'h0;
		tick(4);
	endtask
	task automatic stop();
		sdaLow <= 1'h1;
		tick(4);
		scl <= 1'h1;
		tick(4);
		sdaLow <= 1'h0;
		tick(4);
	endtask
	// Byte MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic ackBit,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
		bitIo(ackBit, r);
		ack = !r;
	endtask
endmodule

// file: dv/ves_status_properties.sv
// Purpose: Port checks for the status and line mask block.
// Assumes: PAL line offsets in the window checks.
// Notes:   Field counter is internal, so checks span both fields.
`timescale 1ns/1ns
module ves_status_properties (
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire logic                     scl,
	input wire logic                     sdaIn,
	input wire logic                     sdaOut,
	input wire logic                     sdaOe,
	input wire logic                     palMode,
	input wire logic [9:0]               lineNumber,
	input wire ves_pkg::ves_ttx_window_s window,
	input wire logic                     teletextInsertEnable,
	input wire logic                     ttxInsertWindow
);
	import ves_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Lines outside both field windows with PAL offsets
	wire below = palMode && lineNumber <= {2'h0, window.oddFirstLine}
		&& lineNumber <= {2'h0, window.evenFirstLine};
	wire above = palMode && lineNumber > {2'h0, window.oddLastLine}
		&& lineNumber > {2'h0, window.evenLastLine};
	// Stop condition, and a held drive of the data line
	sequence stopSeen;
		scl && $past(scl) && $rose(sdaIn);
	endsequence
	sequence oeHold;
		sdaOe [*3];
	endsequence
	a_enable_low_closed: assert property (!teletextInsertEnable |=>
		!ttxInsertWindow) else $error("window open while disabled");
	a_open_needs_enable: assert property (ttxInsertWindow |->
		$past(teletextInsertEnable)) else $error("window without enable");
	a_below_first_closed: assert property (below |=>
		!ttxInsertWindow) else $error("window open before first line");
	a_above_last_closed: assert property (above |=>
		!ttxInsertWindow) else $error("window open after last line");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !scl)
		else $error("data drive changed while clock high");
	a_oe_held_bit: assert property ($rose(sdaOe) |-> oeHold)
		else $error("data drive released too soon");
	a_stop_released: assert property (stopSeen |-> ##[1:2] !sdaOe)
		else $error("data line held after stop");
	a_sda_out_low: assert property (sdaOut == 1'h0)
		else $error("open drain output not low");
endmodule

// file: rtl/ves_pkg.sv
// Purpose: Shared constants and types for the encoder status and
//          teletext line mask block.
// Assumes: Serial bus addresses are 8-bit values including the R/W bit.
// Notes:   All offsets and field positions, and the line mask and caption flag reset values, live here.
package ves_pkg;

	// Serial bus slave addresses, write form; read form has bit 0 set
	localparam logic [7:0] BUS_ADDR_A       = 8'h88;
	localparam logic [7:0] BUS_ADDR_B       = 8'h8c;
	localparam logic [7:0] BUS_ADDR_RW_MASK = 8'hfe;

	// Subaddresses acted on by this block
	localparam logic [7:0] SUB_CC_ODD_0     = 8'h67;
	localparam logic [7:0] SUB_CC_ODD_1     = 8'h68;
	localparam logic [7:0] SUB_CC_EVEN_0    = 8'h69;
	localparam logic [7:0] SUB_CC_EVEN_1    = 8'h6a;
	localparam logic [7:0] SUB_LINE_MASK_LO = 8'h7e;
	localparam logic [7:0] SUB_LINE_MASK_HI = 8'h7f;

	// Status byte field positions
	localparam int STAT_VERSION_MSB = 7;
	localparam int STAT_VERSION_LSB = 5;
	localparam int STAT_CC_ODD      = 4;
	localparam int STAT_CC_EVEN     = 3;
	localparam int STAT_SEQ_MSB     = 2;
	localparam int STAT_SEQ_LSB     = 0;

	// Reset values
	localparam logic [7:0] LINE_MASK_RESET = 8'h00;
	localparam logic       CC_DONE_RESET   = 1'b0;

	// Field sequence wrap points (4 fields NTSC, 8 fields PAL)
	localparam logic [2:0] SEQ_LAST_NTSC = 3'h3;
	localparam logic [2:0] SEQ_LAST_PAL  = 3'h7;

	// Line window offsets: M-systems and other systems
	localparam logic [9:0] FIRST_OFS_M     = 10'h004;
	localparam logic [9:0] FIRST_OFS_OTHER = 10'h001;
	localparam logic [9:0] LAST_OFS_M      = 10'h003;
	localparam logic [9:0] LAST_OFS_OTHER  = 10'h000;

	// Line vetoed by mask bit 0; bit i vetoes this line plus i
	localparam logic [9:0] MASK_FIRST_LINE = 10'h005;
	localparam logic [9:0] MASK_LINES      = 10'h010;

	// Bit counter value at the end of a byte
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Serial slave states
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_SUB      = 4'b0011,
		ST_SUB_ACK  = 4'b0100,
		ST_WDATA    = 4'b0101,
		ST_WDAT_ACK = 4'b0110,
		ST_RDATA    = 4'b0111,
		ST_RACK     = 4'b1000
	} ves_state_e;

	// Teletext line window settings from the write register bank
	typedef struct packed {
		logic [7:0] oddFirstLine;
		logic [7:0] oddLastLine;
		logic [7:0] evenFirstLine;
		logic [7:0] evenLastLine;
	} ves_ttx_window_s;

endpackage

// file: rtl/ves_status_top.sv
// Purpose: Serial bus slave for the encoder status byte and the teletext
//          line mask, plus the field sequence counter.
// Assumes: SCL and SDA are synchronous to clk and change far slower.
// Notes:   SDA is open drain; sdaOut stays low and sdaOe pulls the line.
`timescale 1ns/1ns
module ves_status_top #(
	parameter logic [2:0] VERSION_CODE = 3'h5 // Arbitrary value
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     scl,
	input  wire logic                     sdaIn,
	output logic                          sdaOut,
	output logic                          sdaOe,
	input  wire logic                     palMode,
	input  wire logic                     fieldStart,
	input  wire logic                     oddCaptionEncoded,
	input  wire logic                     evenCaptionEncoded,
	input  wire logic [9:0]               lineNumber,
	input  wire ves_pkg::ves_ttx_window_s window,
	input  wire logic                     teletextInsertEnable,
	output logic                          ttxInsertWindow
);
	import ves_pkg::*;

	ves_state_e  state;
	ves_state_e  next_state;
	logic        sclPrev;
	logic        sdaPrev;
	logic [3:0]  bitCount;
	logic [7:0]  rxShift;
	logic [7:0]  txShift;
	logic [7:0]  subAddr;
	logic        readMode;
	logic        masterAck;
	logic [7:0]  lineMaskLow;
	logic [7:0]  lineMaskHigh;
	logic        oddCaptionDone;
	logic        evenCaptionDone;
	logic [2:0]  fieldSequence;
	logic        writeStrobe;
	logic [7:0]  writeSub;
	logic [7:0]  writeData;

	logic        sclRise;
	logic        sclFall;
	logic        busStart;
	logic        busStop;
	logic        byteDone;
	logic        addrMatch;
	logic [7:0]  statusByte;
	logic        wrMaskLow;
	logic        wrMaskHigh;
	logic        wrCcOdd;
	logic        wrCcEven;
	logic [2:0]  seqLast;

	// Bus condition detection; inputs are already in the clk domain
	assign sclRise  = scl && !sclPrev;
	assign sclFall  = !scl && sclPrev;
	assign busStart = scl && sclPrev && sdaPrev && !sdaIn;
	assign busStop  = scl && sclPrev && !sdaPrev && sdaIn;
	assign byteDone = sclFall && (bitCount == BITS_PER_BYTE);
	assign addrMatch = ((rxShift & BUS_ADDR_RW_MASK) == BUS_ADDR_A) ||
	                   ((rxShift & BUS_ADDR_RW_MASK) == BUS_ADDR_B);

	// Live status byte; captured into txShift at each byte start
	assign statusByte[STAT_VERSION_MSB:STAT_VERSION_LSB] =
		VERSION_CODE;
	assign statusByte[STAT_CC_ODD]  = oddCaptionDone;
	assign statusByte[STAT_CC_EVEN] = evenCaptionDone;
	assign statusByte[STAT_SEQ_MSB:STAT_SEQ_LSB] =
		fieldSequence;

	// Write decode from the one-cycle strobe
	assign wrMaskLow  = writeStrobe && (writeSub == SUB_LINE_MASK_LO);
	assign wrMaskHigh = writeStrobe && (writeSub == SUB_LINE_MASK_HI);
	assign wrCcOdd    = writeStrobe && ((writeSub == SUB_CC_ODD_0) ||
	                                    (writeSub == SUB_CC_ODD_1));
	assign wrCcEven   = writeStrobe && ((writeSub == SUB_CC_EVEN_0) ||
	                                    (writeSub == SUB_CC_EVEN_1));
	assign seqLast    = palMode ? SEQ_LAST_PAL : SEQ_LAST_NTSC;

	// Next state of the serial slave; start and stop override anything
	always_comb begin
		next_state = state;
		if (busStart) begin
			next_state = ST_ADDR;
		end else if (busStop) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_ADDR: begin
					if (byteDone) begin
						next_state = addrMatch ? ST_ADDR_ACK : ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					if (sclFall) begin
						next_state = readMode ? ST_RDATA : ST_SUB;
					end
				end
				ST_SUB: begin
					if (byteDone) begin
						next_state = ST_SUB_ACK;
					end
				end
				ST_SUB_ACK: begin
					if (sclFall) begin
						next_state = ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (byteDone) begin
						next_state = ST_WDAT_ACK;
					end
				end
				ST_WDAT_ACK: begin
					if (sclFall) begin
						next_state = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (byteDone) begin
						next_state = ST_RACK;
					end
				end
				ST_RACK: begin
					if (sclFall) begin
						next_state = masterAck ? ST_RDATA : ST_IDLE;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	// State and edge history
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state   <= ST_IDLE;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			state   <= next_state;
			sclPrev <= scl;
			sdaPrev <= sdaIn;
		end
	end

	// Bit counter and receive shifter, clocked on SCL rising edges
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bitCount <= 4'h0;
			rxShift  <= 8'h00;
		end else if (busStart || (sclFall && (state != next_state))) begin
			bitCount <= 4'h0;
		end else if (sclRise) begin
			bitCount <= bitCount + 4'h1;
			rxShift  <= {rxShift[6:0], sdaIn};
		end
	end

	// Direction bit, master acknowledge and subaddress tracking
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			readMode  <= 1'b0;
			masterAck <= 1'b0;
			subAddr   <= 8'h00;
		end else begin
			if (state == ST_ADDR && byteDone) begin
				readMode <= rxShift[0];
			end
			if (state == ST_RACK && sclRise) begin
				masterAck <= !sdaIn;
			end
			if (state == ST_SUB && byteDone) begin
				subAddr <= rxShift;
			end else if (state == ST_WDATA && byteDone) begin
				subAddr <= subAddr + 8'h01; // Auto-increment
			end
		end
	end

	// One-cycle write strobe at the end of each data byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			writeStrobe <= 1'b0;
			writeSub    <= 8'h00;
			writeData   <= 8'h00;
		end else begin
			writeStrobe <= (state == ST_WDATA) && byteDone && !busStart;
			writeSub    <= subAddr;
			writeData   <= rxShift;
		end
	end

	// SDA drive: open drain, so the enable carries the data
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sdaOut  <= 1'b0;
			sdaOe   <= 1'b0;
			txShift <= 8'h00;
		end else if (busStart || busStop) begin
			sdaOe <= 1'b0;
		end else if (sclFall) begin
			if (next_state == ST_ADDR_ACK || next_state == ST_SUB_ACK ||
			    next_state == ST_WDAT_ACK) begin
				sdaOe <= 1'b1;
			end else if (next_state == ST_RDATA && state != ST_RDATA) begin
				// Snapshot so all eight bits share one moment
				sdaOe   <= !statusByte[7];
				txShift <= {statusByte[6:0], 1'b0};
			end else if (next_state == ST_RDATA) begin
				sdaOe   <= !txShift[7];
				txShift <= {txShift[6:0], 1'b0};
			end else begin
				sdaOe <= 1'b0; // Release for master acknowledge
			end
		end
	end

	// Line mask bytes feed the teletext gate directly
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lineMaskLow  <= LINE_MASK_RESET;
			lineMaskHigh <= LINE_MASK_RESET;
		end else begin
			if (wrMaskLow) begin
				lineMaskLow <= writeData;
			end
			if (wrMaskHigh) begin
				lineMaskHigh <= writeData;
			end
		end
	end

	// Caption flags: an encode in the clearing cycle still sets the flag
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			oddCaptionDone  <= CC_DONE_RESET;
			evenCaptionDone <= CC_DONE_RESET;
		end else begin
			if (oddCaptionEncoded) begin
				oddCaptionDone <= 1'b1;
			end else if (wrCcOdd) begin
				oddCaptionDone <= 1'b0;
			end
			if (evenCaptionEncoded) begin
				evenCaptionDone <= 1'b1;
			end else if (wrCcEven) begin
				evenCaptionDone <= 1'b0;
			end
		end
	end

	// Field sequence: bit 0 is one in even fields, count 0 is odd
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fieldSequence <= 3'h0;
		end else if (fieldStart) begin
			if (fieldSequence >= seqLast) begin
				fieldSequence <= 3'h0;
			end else begin
				fieldSequence <= fieldSequence + 3'h1;
			end
		end
	end

	// Teletext insertion window gate
	ves_ttx_gate u_gate (
		.clk          (clk),
		.rst_b        (rst_b),
		.lineNumber   (lineNumber),
		.evenField    (fieldSequence[0]),
		.mSystem      (!palMode),
		.window       (window),
		.lineMask     ({lineMaskHigh, lineMaskLow}),
		.insertEnable (teletextInsertEnable),
		.insertWindow (ttxInsertWindow)
	);
endmodule

// file: rtl/ves_ttx_gate.sv
// Purpose: Opens the teletext insertion window for the current line.
// Assumes: lineNumber uses 50 Hz counting and is stable within a line.
// Notes:   Output is registered, one cycle behind its inputs.
`timescale 1ns/1ns
module ves_ttx_gate (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic [9:0]               lineNumber,
	input  wire logic                     evenField,
	input  wire logic                     mSystem,
	input  wire ves_pkg::ves_ttx_window_s window,
	input  wire logic [15:0]              lineMask,
	input  wire logic                     insertEnable,
	output logic                          insertWindow
);
	import ves_pkg::*;

	logic [9:0] firstOfs;
	logic [9:0] lastOfs;
	logic [9:0] firstLine;
	logic [9:0] lastLine;
	logic [9:0] maskIndex;
	logic       inWindow;
	logic       vetoed;
	logic       next_insertWindow;

	// Window limits depend on the field and on the line standard
	assign firstOfs  = mSystem ? FIRST_OFS_M : FIRST_OFS_OTHER;
	assign lastOfs   = mSystem ? LAST_OFS_M : LAST_OFS_OTHER;
	assign firstLine = firstOfs + {2'h0, evenField ? window.evenFirstLine
	                                               : window.oddFirstLine};
	assign lastLine  = lastOfs + {2'h0, evenField ? window.evenLastLine
	                                              : window.oddLastLine};
	assign inWindow  = (lineNumber >= firstLine) && (lineNumber <= lastLine);

	// Mask only vetoes; it can never open a line outside the window
	assign maskIndex = lineNumber - MASK_FIRST_LINE;
	assign vetoed    = (lineNumber >= MASK_FIRST_LINE) &&
	                   (maskIndex < MASK_LINES) && lineMask[maskIndex[3:0]];
	assign next_insertWindow = insertEnable && inWindow &&
	                           !vetoed;

	// Registered so the top output comes from a flip-flop
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			insertWindow <= 1'b0;
		end else begin
			insertWindow <= next_insertWindow;
		end
	end
endmodule
